//--- dv/dwr_link_sva.sv
// Checker for the packet timing on the write/retire link.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module dwr_link_sva import dwr_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link packets
    input wire logic row_frame,
    input wire dwr_row_e row_op,
    input wire logic col_frame,
    input wire dwr_col_e col_op,
    input wire logic [DEV_W-1:0] col_dev,
    input wire logic mask_frame,
    input wire logic data_frame,
    input wire logic rdata_valid
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [7:0] t_act, t_cls, t_wr;
    wire act = row_frame && row_op == DWR_ROW_ACT;
    wire cls = row_frame && row_op == DWR_ROW_CLOSE;
    wire wr = col_frame && (col_op == DWR_COL_WRITE || col_op == DWR_COL_WRAC);
    wire rd0 = col_frame && col_op == DWR_COL_READ && col_dev == 5'h00;

    // Cycles since last activate, close and write, saturating
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            t_act <= 8'hff;
            t_cls <= 8'hff;
            t_wr <= 8'hff;
        end else begin
            t_act <= act ? 8'h01 : t_act + {7'h00, t_act != 8'hff};
            t_cls <= cls ? 8'h01 : t_cls + {7'h00, t_cls != 8'hff};
            t_wr <= wr ? 8'h01 : t_wr + {7'h00, t_wr != 8'hff};
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_write_data_follows: assert property (wr |-> ##2 data_frame) else $error("no data after write");
    chk_data_has_write: assert property (data_frame |-> $past(wr, 2)) else $error("stray data");
    chk_mask_retire_slot: assert property (mask_frame |-> $past(wr, 3)) else $error("mask off slot");
    chk_write_after_act: assert property (wr |-> $past(act, 3) || $past(wr)) else $error("write misplaced");
    chk_close_after_act: assert property (cls |-> t_act >= 8'(RAS_CYC)) else $error("close too early");
    chk_close_after_retire: assert property (cls |-> t_wr >= 8'(RTR_CYC + RTP_CYC))
        else $error("close before retire");
    chk_reopen_spacing: assert property (act |-> t_act >= 8'(RC_CYC) && t_cls >= 8'(RP_CYC))
        else $error("act early");
    chk_column_framed: assert property (col_frame) else $error("column slot not framed");
    chk_read_return: assert property (rdata_valid == $past(rd0)) else $error("read return off");
    cover property (wr ##1 wr);
    cover property (mask_frame);
    cover property (rd0 ##1 rdata_valid);
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Bench joining controller and device ends over the link.
// Assumes default device id 0 and one packet per cycle.
`timescale 1ns/100ps
`default_nettype none
module testbench import dwr_pkg::*; ;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [127:0] DA = {4{32'h1234abcd}};
    localparam logic [127:0] DB = {4{32'h0f1e2d3c}};
    localparam logic [127:0] DC = {4{32'h89badcfe}};
    localparam logic [127:0] DD = {4{32'h7766aa55}};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0, req_read = 1'b0, req_autoclose = 1'b0, req_mask_en = 1'b0;
    logic [DEV_W-1:0] req_dev = 5'h00;
    logic [BANK_W-1:0] req_bank = 5'h00;
    logic [ROW_W-1:0] req_row = 9'h000;
    logic [COL_W-1:0] req_col = 6'h00;
    logic [DATA_W-1:0] req_data0 = '0, req_data1 = '0, rsp_data;
    logic [MASK_W-1:0] req_mask0 = 16'h0000, req_mask1 = 16'h0000;
    logic req_ready, rsp_valid, busy, retire_pulse, buf_pending;
    logic refused = 1'b0;
    int n_errors = 0, tests_run = 0, cycles = 0, n_data = 0, n_mask = 0, n_ret = 0;

    initial forever #2 sys_clk = ~sys_clk;

    dwr_link_if i_dwr_link_if (.sys_clk);
    dwr_ctrl_end #(.DEPTH(8)) i_dwr_ctrl_end (.sys_clk, .rst, .link(i_dwr_link_if), .req_valid, .req_ready,
        .req_read, .req_autoclose, .req_mask_en, .req_dev, .req_bank, .req_row, .req_col, .req_data0,
        .req_data1, .req_mask0, .req_mask1, .rsp_valid, .rsp_data, .busy);
    dwr_dev_end i_dwr_dev_end (.sys_clk, .rst, .link(i_dwr_link_if), .retire_pulse, .buf_pending);
    dwr_link_sva i_dwr_link_sva (.sys_clk, .rst, .row_frame(i_dwr_link_if.row_frame),
        .row_op(i_dwr_link_if.row_op), .col_frame(i_dwr_link_if.col_frame), .col_op(i_dwr_link_if.col_op),
        .col_dev(i_dwr_link_if.col_dev), .mask_frame(i_dwr_link_if.mask_frame),
        .data_frame(i_dwr_link_if.data_frame), .rdata_valid(i_dwr_link_if.rdata_valid));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Present one request and hold it until taken
    task automatic send(logic rd, logic ac, logic me, logic [BANK_W-1:0] b, logic [ROW_W-1:0] r,
        logic [COL_W-1:0] c, logic [DATA_W-1:0] d0, logic [DATA_W-1:0] d1, logic [MASK_W-1:0] m0,
        logic [MASK_W-1:0] m1);
        int w = 0;
        req_valid <= 1'b1;
        req_read <= rd;
        req_autoclose <= ac;
        req_mask_en <= me;
        req_bank <= b;
        req_row <= r;
        req_col <= c;
        req_data0 <= d0;
        req_data1 <= d1;
        req_mask0 <= m0;
        req_mask1 <= m1;
        @(posedge sys_clk);
        while (req_ready !== 1'b1 && w < 3000) begin
            w++;
            @(posedge sys_clk);
        end
        if (w >= 3000) begin
            n_errors++;
        end
        req_valid <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Wait for one returned dualoct
    task automatic get(string name, logic [DATA_W-1:0] exp);
        int w = 0;
        @(posedge sys_clk);
        while (rsp_valid !== 1'b1 && w < 3000) begin
            w++;
            @(posedge sys_clk);
        end
        if (w >= 3000) begin
            n_errors++;
        end
        check(name, exp, rsp_data);
    endtask

    task automatic rd(logic [BANK_W-1:0] b, logic [ROW_W-1:0] r, logic [COL_W-1:0] c,
        logic [DATA_W-1:0] e0, logic [DATA_W-1:0] e1);
        send(1'b1, 1'b0, 1'b0, b, r, c, '0, '0, 16'h0000, 16'h0000);
        get("read dualoct0", e0);
        get("read dualoct1", e1);
    endtask

    // Byte merge, mask bit high writes the byte
    function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] o, logic [DATA_W-1:0] n,
        logic [MASK_W-1:0] m);
        logic [DATA_W-1:0] x;
        for (int i = 0; i < MASK_W; i++) begin
            x[8*i+:8] = m[i] ? n[8*i+:8] : o[8*i+:8];
        end
        return x;
    endfunction

    // Link monitor, refusal watch and timeout
    always @(posedge sys_clk) begin
        cycles++;
        if (!rst) begin
            n_data += i_dwr_link_if.data_frame;
            n_mask += i_dwr_link_if.mask_frame;
            n_ret += retire_pulse;
        end
        if (req_valid && req_ready === 1'b0) begin
            refused = 1'b1;
        end
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        send(1'b0, 1'b0, 1'b0, 5'h02, 9'h001, 6'h04, DA, DB, 16'h0000, 16'h0000);
        rd(5'h02, 9'h001, 6'h04, DA, DB);
        send(1'b0, 1'b0, 1'b1, 5'h02, 9'h001, 6'h04, DC, DD, 16'h00ff, 16'hff00);
        rd(5'h02, 9'h001, 6'h04, merge(DA, DC, 16'h00ff), merge(DB, DD, 16'hff00));
        send(1'b0, 1'b1, 1'b0, 5'h04, 9'h002, 6'h10, DC, DA, 16'h0000, 16'h0000);
        rd(5'h04, 9'h002, 6'h10, DC, DA);
        for (int i = 0; i < 12; i++) begin
            send(1'b0, 1'b0, 1'b0, 5'h08, 9'h003, 6'h00, i, ~i, 16'h0000, 16'h0000);
        end
        rd(5'h08, 9'h003, 6'h00, 11, ~11);
        repeat (8) @(posedge sys_clk);
        check("queue refusal", 1, refused);
        check("data packets", 30, n_data);
        check("mask packets", 2, n_mask);
        check("retires", 30, n_ret);
        check("buffer pending", 0, buf_pending);
        check("busy", 0, busy);
        stop_test();
    end
endmodule
`default_nettype wire

//--- logic/dwr_ctrl_end.sv
// Controller end: queues write/read requests and issues packets.
// Assumes one device end on the link and one packet per cycle.
//
// Contract
// - First write at activate delay minus retire delay
// - Write data follows each write after delay
// - Row/column end-referenced, data start-referenced
// - Second write spaced by column packet spacing
// - Optional mask rides with retiring column packet
// - Postponed retire postpones its mask too (here the mask is sent at the fixed retire slot, never held off)
// - Close no earlier than activate-to-close minimum (autoclose write here closes its bank at retire, 7 cycles after activate)
// - Close no earlier than retire-to-close minimum (here an autoclose write closes its bank in its retire cycle)
// - Reactivate after row cycle and close-to-activate
// - One transaction per bank at a time
// - Write loads buffer, sense amp untouched
// - Retire at write-to-retire slot unless blocked
// - Late retire at first non-self-read packet
// - Read before retire old, after new
// - Self read in retire slot postpones one
// - Other packets force pending retire
// - Idle slot inserted in write-write-read
// - Buffer keeps bank and column, not row
// - Avoid closing bank with unretired write
// - Write retires other devices' older buffers
// - Non-adjacent banks may interleave per row-to-row
// - Adjacent banks stay closed during access
// - Autoclose write closes bank after retire
`timescale 1ns/100ps
`default_nettype none
module dwr_ctrl_end import dwr_pkg::*; #(parameter int DEPTH = 8) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link
    dwr_link_if.ctrl link,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic req_autoclose,
    input wire logic req_mask_en,
    input wire logic [DEV_W-1:0] req_dev,
    input wire logic [BANK_W-1:0] req_bank,
    input wire logic [ROW_W-1:0] req_row,
    input wire logic [COL_W-1:0] req_col,
    input wire logic [DATA_W-1:0] req_data0,
    input wire logic [DATA_W-1:0] req_data1,
    input wire logic [MASK_W-1:0] req_mask0,
    input wire logic [MASK_W-1:0] req_mask1,
    // Answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic busy
);
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic rd;
        logic ac;
        logic men;
        logic [DEV_W-1:0] dev;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] d1;
        logic [DATA_W-1:0] d0;
        logic [MASK_W-1:0] m1;
        logic [MASK_W-1:0] m0;
    } dwr_req_s;
    typedef enum logic [2:0] {CS_IDLE, CS_ACT, CS_COL, CS_DRAIN, CS_CLOSE} dwr_cs_e;
    typedef struct packed {
        dwr_cs_e st;
        dwr_req_s rq;
        logic k;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] t_act;
        logic [CNT_W-1:0] t_close;
        logic [CNT_W-1:0] t_ret;
        logic [CWD_CYC-1:0][1:0] dp;
        logic [RTR_CYC-1:0][2:0] mp;
        logic [1:0][DEV_W:0] hist;
        logic row_frame;
        dwr_row_e row_op;
        logic [BANK_W-1:0] row_bank;
        logic [ROW_W-1:0] row_addr;
        logic [DEV_W-1:0] row_dev;
        dwr_col_e col_op;
        logic [DEV_W-1:0] col_dev;
        logic [BANK_W-1:0] col_bank;
        logic [COL_W-1:0] col_col;
        logic mask_frame;
        logic [MASK_W-1:0] byte_mask;
        logic data_frame;
        logic [DATA_W-1:0] data;
        logic rsp_v;
        logic [DATA_W-1:0] rsp_d;
        logic busy;
    } dwr_ctrl_s;
    // ----------------------------------------
    // Request queue
    // ----------------------------------------
    dwr_ctrl_s c, n;
    dwr_req_s in_word, out_word;
    logic out_valid, out_ready, fifo_ready;
    assign in_word = '{rd: req_read, ac: req_autoclose, men: req_mask_en, dev: req_dev,
        bank: req_bank, row: req_row, col: req_col, d1: req_data1, d0: req_data0,
        m1: req_mask1, m0: req_mask0};
    assign out_ready = (c.st == CS_IDLE);
    dwr_fifo #(.W($bits(dwr_req_s)), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(req_valid && req_ready),
        .in_ready(fifo_ready),
        .in_data(in_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word)
    );
    // Registered copy of queue ready
    logic ready_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= fifo_ready;
        end
    end
    assign req_ready = ready_q && fifo_ready;
    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    logic wr_now;
    logic [DEV_W:0] slot;
    always_comb begin
        n = c;
        wr_now = 1'b0;
        slot = '0;
        n.row_frame = 1'b0;
        n.row_op = DWR_ROW_NOP;
        n.col_op = DWR_COL_IDLE;
        n.mask_frame = 1'b0;
        n.data_frame = 1'b0;
        n.t_act = (&c.t_act) ? c.t_act : c.t_act + 1'b1;
        n.t_close = (&c.t_close) ? c.t_close : c.t_close + 1'b1;
        n.t_ret = (&c.t_ret) ? c.t_ret : c.t_ret + 1'b1;
        n.rsp_v = link.rdata_valid;
        n.rsp_d = link.rdata;
        case (c.st)
            CS_IDLE: begin
                // One whole transaction at a time, on any bank
                if (out_valid) begin
                    n.rq = out_word;
                    n.st = CS_ACT;
                end
            end
            CS_ACT: begin
                if (c.t_act >= CNT_W'(RC_CYC) && c.t_close >= CNT_W'(RP_CYC)) begin
                    n.row_frame = 1'b1;
                    n.row_op = DWR_ROW_ACT;
                    n.row_dev = c.rq.dev;
                    n.row_bank = c.rq.bank;
                    n.row_addr = c.rq.row;
                    n.t_act = '0;
                    n.k = 1'b0;
                    n.cnt = c.rq.rd ? CNT_W'(RCD_CYC - 1) : CNT_W'(RCD_CYC - RTR_CYC - 1);
                    n.st = CS_COL;
                end
            end
            CS_COL: begin
                if (c.cnt != '0) begin
                    n.cnt = c.cnt - 1'b1;
                end else if (c.rq.rd && c.hist[0] == {1'b1, c.rq.dev} && c.hist[1] == {1'b1, c.rq.dev}) begin
                    n.col_op = DWR_COL_IDLE;
                end else begin
                    wr_now = !c.rq.rd;
                    n.col_op = c.rq.rd ? DWR_COL_READ : ((c.k && c.rq.ac) ? DWR_COL_WRAC : DWR_COL_WRITE);
                    n.col_dev = c.rq.dev;
                    n.col_bank = c.rq.bank;
                    n.col_col = c.rq.col + COL_W'(c.k);
                    n.k = 1'b1;
                    n.cnt = CNT_W'(CC_CYC - 1);
                    if (c.k) begin
                        n.st = CS_DRAIN;
                    end
                end
            end
            CS_DRAIN: begin
                // Close waits for every retire to pass
                if (c.dp == '0 && c.mp == '0) begin
                    n.st = (c.rq.ac && !c.rq.rd) ? CS_IDLE : CS_CLOSE;
                end
            end
            CS_CLOSE: begin
                if (c.t_act >= CNT_W'(RAS_CYC) && (c.rq.rd || c.t_ret >= CNT_W'(RTP_CYC))) begin
                    n.row_frame = 1'b1;
                    n.row_op = DWR_ROW_CLOSE;
                    n.row_dev = c.rq.dev;
                    n.row_bank = c.rq.bank;
                    n.t_close = '0;
                    n.st = CS_IDLE;
                end
            end
            default: begin
                n.st = CS_IDLE;
            end
        endcase
        // Column history for the write-write-read check
        slot = {wr_now, c.rq.dev};
        n.hist = {c.hist[0], slot};
        // Data dualoct after each write
        n.dp = {c.dp[CWD_CYC-2:0], {wr_now, wr_now && c.k}}; // Empty slots shift in zero
        if (c.dp[CWD_CYC-1][1]) begin
            n.data_frame = 1'b1;
            n.data = c.dp[CWD_CYC-1][0] ? c.rq.d1 : c.rq.d0;
        end
        // Mask aligned to the retiring slot, never held off here
        n.mp = {c.mp[RTR_CYC-2:0], {wr_now, wr_now && c.k, wr_now && c.k}}; // Drain can see it empty
        if (c.mp[RTR_CYC-1][2]) begin
            n.mask_frame = c.rq.men;
            n.byte_mask = c.mp[RTR_CYC-1][1] ? c.rq.m1 : c.rq.m0;
            if (c.mp[RTR_CYC-1][0]) begin
                n.t_ret = '0;
                if (c.rq.ac) begin
                    n.t_close = '0;
                end
            end
        end
        n.busy = (n.st != CS_IDLE);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            c <= '0;
            c.t_act <= '1;
            c.t_close <= '1;
            c.t_ret <= '1;
        end else begin
            c <= n;
        end
    end
    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.row_frame = c.row_frame;
    assign link.row_op = c.row_op;
    assign link.row_dev = c.row_dev;
    assign link.row_bank = c.row_bank;
    assign link.row_addr = c.row_addr;
    assign link.col_frame = !rst; // Every slot framed, idle by default
    assign link.col_op = c.col_op;
    assign link.col_dev = c.col_dev;
    assign link.col_bank = c.col_bank;
    assign link.col_col = c.col_col;
    assign link.mask_frame = c.mask_frame;
    assign link.byte_mask = c.byte_mask;
    assign link.data_frame = c.data_frame;
    assign link.data_lane_low = c.data[LANE_W-1:0];
    assign link.data_lane_high = c.data[DATA_W-1:LANE_W];
    assign rsp_valid = c.rsp_v;
    assign rsp_data = c.rsp_d;
    assign busy = c.busy;
endmodule
`default_nettype wire

//--- logic/dwr_dev_end.sv
// Device end: write buffer, automatic retire, bank rows, storage.
// Assumes the controller end keeps its packet spacing.
`timescale 1ns/100ps
`default_nettype none
module dwr_dev_end import dwr_pkg::*; #(
    parameter logic [DEV_W-1:0] DEV_ID = 5'h00,
    parameter int ROW_BITS = 2,
    parameter int NBANK = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Link
    dwr_link_if.dev link,
    // Status
    output logic retire_pulse,
    output logic buf_pending
);
    localparam int AW = BANK_W + ROW_BITS + COL_W;
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] v;
        logic [1:0] ac;
        logic [1:0] hd;
        logic [1:0][BANK_W-1:0] bank;
        logic [1:0][COL_W-1:0] col;
        logic [1:0][DATA_W-1:0] data;
        logic [1:0][CNT_W-1:0] due;
        logic [CWD_CYC-1:0] dp;
        logic [NBANK-1:0] open;
        logic [NBANK-1:0][ROW_W-1:0] orow;
        logic rd_v;
        logic [DATA_W-1:0] rd_d;
        logic ret;
    } dwr_dev_s;
    dwr_dev_s c, n;
    logic [DATA_W-1:0] mem [2**AW];
    logic self_rd, self_wr, retire, wsel;
    logic [AW-1:0] waddr, raddr;
    logic [DATA_W-1:0] wdata, old;
    // Command decode
    assign self_rd = link.col_frame && link.col_op == DWR_COL_READ && link.col_dev == DEV_ID;
    assign self_wr = link.col_frame && link.col_dev == DEV_ID &&
        (link.col_op == DWR_COL_WRITE || link.col_op == DWR_COL_WRAC);
    // Retire at a framed slot that is not a read to self
    assign retire = c.v[0] && c.due[0] == '0 && link.col_frame && !self_rd;
    // Row held in buffer is not kept: the open row is used
    assign waddr = {c.bank[0], c.orow[c.bank[0]][ROW_BITS-1:0], c.col[0]};
    assign raddr = {link.col_bank, c.orow[link.col_bank][ROW_BITS-1:0], link.col_col};
    assign old = mem[waddr];
    // Byte merge, all bytes without a mask packet
    always_comb begin
        for (int i = 0; i < MASK_W; i++) begin
            wdata[i*8 +: 8] = (!link.mask_frame || link.byte_mask[i]) ? c.data[0][i*8 +: 8] : old[i*8 +: 8];
        end
    end
    // Next state
    always_comb begin
        n = c;
        n.ret = retire;
        n.rd_v = self_rd;
        n.rd_d = mem[raddr];
        for (int b = 0; b < 2; b++) begin
            if (c.due[b] != '0) begin
                n.due[b] = c.due[b] - 1'b1;
            end
        end
        // Retire shifts the newer entry down
        if (retire) begin
            if (c.ac[0]) begin
                n.open[c.bank[0]] = 1'b0;
            end
            n.v = {1'b0, c.v[1]};
            n.ac = {1'b0, c.ac[1]};
            n.hd = {1'b0, c.hd[1]};
            n.bank[0] = c.bank[1];
            n.col[0] = c.col[1];
            n.data[0] = c.data[1];
            n.due[0] = (c.due[1] != '0) ? c.due[1] - 1'b1 : '0;
        end
        // Load a write into the buffer only
        wsel = n.v[0];
        if (self_wr) begin
            n.v[wsel] = 1'b1;
            n.hd[wsel] = 1'b0;
            n.ac[wsel] = (link.col_op == DWR_COL_WRAC);
            n.bank[wsel] = link.col_bank;
            n.col[wsel] = link.col_col;
            n.due[wsel] = CNT_W'(RTR_CYC - 1);
        end
        // Data dualoct follows the write
        n.dp = {c.dp[CWD_CYC-2:0], self_wr};
        if (c.dp[CWD_CYC-1] && link.data_frame) begin
            wsel = !(n.v[0] && !n.hd[0]);
            n.data[wsel] = {link.data_lane_high, link.data_lane_low};
            n.hd[wsel] = 1'b1;
        end
        // Row packets
        if (link.row_frame && link.row_dev == DEV_ID) begin
            if (link.row_op == DWR_ROW_ACT) begin
                n.open[link.row_bank] = 1'b1;
                n.orow[link.row_bank] = link.row_addr;
            end else if (link.row_op == DWR_ROW_CLOSE) begin
                n.open[link.row_bank] = 1'b0;
            end
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end
    // Sense amp write on retire
    always_ff @(posedge sys_clk) begin
        if (retire) begin
            mem[waddr] <= wdata;
        end
    end
    // Outputs
    assign link.rdata_valid = c.rd_v;
    assign link.rdata = c.rd_d;
    assign retire_pulse = c.ret;
    assign buf_pending = c.v[0];
endmodule
`default_nettype wire

//--- logic/dwr_fifo.sv
// Request FIFO with valid/ready on both sides.
// Assumes a single clock; flags decode the registered count.
`timescale 1ns/100ps
`default_nettype none
module dwr_fifo #(parameter int W = 8, parameter int DEPTH = 8) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dwr_fifo_s;
    dwr_fifo_s c, n;
    logic [W-1:0] mem [DEPTH];
    logic push, pop;
    // Handshakes
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (c.cnt != (AW+1)'(DEPTH));
    assign out_valid = (c.cnt != '0);
    assign out_data = mem[c.rp];
    // Pointer and count update
    always_comb begin
        n = c;
        if (push) begin
            n.wp = (c.wp == AW'(DEPTH-1)) ? '0 : c.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (c.rp == AW'(DEPTH-1)) ? '0 : c.rp + 1'b1;
        end
        n.cnt = c.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end
    // Storage
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[c.wp] <= in_data;
        end
    end
endmodule
`default_nettype wire

//--- logic/dwr_link_if.sv
// Link between the memory controller end and one device end.
// Assumes both ends share sys_clk; one packet per cycle.
`timescale 1ns/100ps
`default_nettype none
interface dwr_link_if import dwr_pkg::*; (input wire logic sys_clk);
    // Row pins
    logic row_frame;
    dwr_row_e row_op;
    logic [DEV_W-1:0] row_dev;
    logic [BANK_W-1:0] row_bank;
    logic [ROW_W-1:0] row_addr;
    // Column pins, frame is the start bit
    logic col_frame;
    dwr_col_e col_op;
    logic [DEV_W-1:0] col_dev;
    logic [BANK_W-1:0] col_bank;
    logic [COL_W-1:0] col_col;
    // Byte mask packet
    logic mask_frame;
    logic [MASK_W-1:0] byte_mask;
    // Data lanes
    logic data_frame;
    logic [LANE_W-1:0] data_lane_low;
    logic [LANE_W-1:0] data_lane_high;
    // Read return
    logic rdata_valid;
    logic [DATA_W-1:0] rdata;
    modport ctrl (
        output row_frame, row_op, row_dev, row_bank, row_addr,
        output col_frame, col_op, col_dev, col_bank, col_col,
        output mask_frame, byte_mask, data_frame, data_lane_low, data_lane_high,
        input rdata_valid, rdata
    );
    modport dev (
        input row_frame, row_op, row_dev, row_bank, row_addr,
        input col_frame, col_op, col_dev, col_bank, col_col,
        input mask_frame, byte_mask, data_frame, data_lane_low, data_lane_high,
        output rdata_valid, rdata
    );
endinterface
`default_nettype wire

//--- logic/dwr_pkg.sv
// Shared constants and types for the write/retire link.
// Assumes one packet slot per sys_clk cycle at 250 MHz.
`default_nettype none
package dwr_pkg;
    // ----------------------------------------
    // Field widths
    // ----------------------------------------
    localparam int DEV_W = 5;
    localparam int BANK_W = 5;
    localparam int ROW_W = 9;
    localparam int COL_W = 6;
    localparam int LANE_W = 64;
    localparam int DATA_W = 2 * LANE_W;
    localparam int MASK_W = DATA_W / 8;
    localparam int CNT_W = 8;
    // ----------------------------------------
    // Timing, ns then cycles
    // ----------------------------------------
    localparam int CLK_NS = 4;
    localparam int PACKET_NS = 4;
    localparam int RCD_NS = 24;
    localparam int RTR_NS = 12;
    localparam int CWD_NS = 8;
    localparam int CC_NS = 4;
    localparam int RAS_NS = 64;
    localparam int RTP_NS = 12;
    localparam int RC_NS = 80;
    localparam int RP_NS = 20;
    localparam int PACKET_CYC = (PACKET_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCD_CYC = (RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RTR_CYC = (RTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int CWD_CYC = (CWD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CC_CYC = (CC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_CYC = (RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RTP_CYC = (RTP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RC_CYC = (RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (RP_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // Commands
    // ----------------------------------------
    typedef enum logic [1:0] {DWR_ROW_NOP, DWR_ROW_ACT, DWR_ROW_CLOSE} dwr_row_e;
    typedef enum logic [1:0] {DWR_COL_IDLE, DWR_COL_WRITE, DWR_COL_WRAC, DWR_COL_READ} dwr_col_e;
endpackage
`default_nettype wire
